/* File: core/usf_flags.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Tx ready bit is 0 while holding register loaded, 1 when free.
// - Enabling transmitter sets tx ready unless loaded; never in echo/remote.
// - Tx ready pin low while bit set; held high in echo/remote loop.
// - Rx ready sets on transfer; clears on data read or receiver off.
// - Tx empty/modem change sets on DSR/DCD change or shifter done.
// - Tx empty clears on tx enable and status read; pin low when set, except held high in remote loop.
// - Parity bit flags parity error, or first DLE in transparent sync.
// - Parity and overrun clear on receiver disable and error reset.
// - Overrun sets when new character lands on an unread one.
// - Async framing bit sets on missing stop bit, first one checked.
// - Nontransparent sync sets framing/sync bit on FIRST_SYNC_CHAR or FIRST_SYNC_CHAR-SECOND_SYNC_CHAR.
// - Transparent sync sets it on initial sync, then on DLE-FIRST_SYNC_CHAR.
// - Framing/sync clears on rx disable, async error reset, sync read.
// - Status bits 6 and 7 show inverted carrier and data set inputs.
// - Command bit0 tx enable, bit2 rx enable, bit1 drives DTR low outside local loop.
// - Error reset bit clears parity, overrun and async framing flags and self-clears.
// - Rx disable drops partial character; tx finishes shift then idles.
// - Sub-mode field: normal, echo/strip, local loop, remote loop.
module usf_flags (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_CHAR_I,
  input wire logic RX_PAR_ERR_I,
  input wire logic RX_STOP_ERR_I,
  input wire logic DSR_N_I,
  input wire logic DCD_N_I,
  output logic TXD_O,
  output logic DTR_N_O,
  output logic RTS_N_O,
  output logic TX_HOLDING_READY_N_O,
  output logic RX_HOLDING_READY_N_O,
  output logic TX_EMPTY_OR_MODEM_CHANGE_N_O,
  output logic [usf_pkg::ST_DSR:0] STATUS_O,
  output logic IRQ_O
);
  import usf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] command_control_reg, mode_reg, dle_reg, sync1_reg, sync2_reg;
  logic [7:0] rx_data_reg, tx_hold_reg, irq_status_reg, irq_enable_reg;
  logic tx_hold_full_reg, tx_ready_reg, rx_ready_reg, tx_empty_reg;
  logic par_reg, ovr_reg, frm_reg, prev_dle_reg, prev_first_sync_char_reg, synced_reg;
  logic dsr_s1_reg, dsr_s2_reg, dcd_s1_reg, dcd_s2_reg;
  logic dsr_old_reg, dcd_old_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_count_reg;
  usf_tx_e tx_state_reg;
  logic [7:0] status, events;
  logic [1:0] sub;
  logic wr, rd, tx_en, rx_en, sub_loopy, sync_mode, transp;
  logic stat_rd, data_rd, tx_load, tx_done, err_rst, modem_chg;
  logic is_dle, is_first_sync_char, is_second_sync_char, syn_hit, rx_en_fall, tx_en_rise;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign tx_en = command_control_reg[CMD_TX_EN];
  assign rx_en = command_control_reg[CMD_RX_EN];
  assign sub = command_control_reg[CMD_SUB_LO+1:CMD_SUB_LO];
  assign sub_loopy = (sub == SUB_ECHO && !mode_reg[MODE_SYNC]) ||
                     (sub == SUB_RLOOP);
  assign sync_mode = mode_reg[MODE_SYNC];
  assign transp = mode_reg[MODE_TRANSP];
  assign stat_rd = rd && PADDR_I == ADDR_STATUS;
  assign data_rd = rd && PADDR_I == ADDR_RX_DATA;
  assign err_rst = wr && PADDR_I == ADDR_COMMAND &&
                   PWDATA_I[CMD_ERR_RST];
  assign rx_en_fall = wr && PADDR_I == ADDR_COMMAND &&
                      !PWDATA_I[CMD_RX_EN];
  assign tx_en_rise = wr && PADDR_I == ADDR_COMMAND &&
                      PWDATA_I[CMD_TX_EN] && !tx_en;
  assign is_dle = hit(RX_CHAR_I, dle_reg);
  assign is_first_sync_char = hit(RX_CHAR_I, sync1_reg);
  assign is_second_sync_char = hit(RX_CHAR_I, sync2_reg);

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (PADDR_I)
        ADDR_COMMAND: PRDATA_O <= {24'h0, command_control_reg};
        ADDR_STATUS: PRDATA_O <= {24'h0, status};
        ADDR_RX_DATA: PRDATA_O <= {24'h0, rx_data_reg};
        ADDR_MODE: PRDATA_O <= {24'h0, mode_reg};
        ADDR_DLE: PRDATA_O <= {24'h0, dle_reg};
        ADDR_SYNC: PRDATA_O <= {16'h0, sync2_reg, sync1_reg};
        ADDR_IRQ_STATUS: PRDATA_O <= {24'h0, irq_status_reg};
        ADDR_IRQ_ENABLE: PRDATA_O <= {24'h0, irq_enable_reg};
        default: PRDATA_O <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      command_control_reg <= RESET_BYTE;
      mode_reg <= RESET_BYTE;
      dle_reg <= RESET_BYTE;
      sync1_reg <= RESET_BYTE;
      sync2_reg <= RESET_BYTE;
      irq_enable_reg <= RESET_BYTE;
    end else if (wr) begin
      unique case (PADDR_I)
        // Error reset bit never stored, so it reads back 0
        ADDR_COMMAND: command_control_reg <=
          PWDATA_I[7:0] & ~(8'h01 << CMD_ERR_RST);
        ADDR_MODE: mode_reg <= PWDATA_I[7:0];
        ADDR_DLE: dle_reg <= PWDATA_I[7:0];
        ADDR_SYNC: begin
          sync1_reg <= PWDATA_I[7:0];
          sync2_reg <= PWDATA_I[15:8];
        end
        ADDR_IRQ_ENABLE: irq_enable_reg <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Modem inputs: two-flop synchronisers, change seen on second stage
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dsr_s1_reg <= 1'b1;
      dsr_s2_reg <= 1'b1;
      dcd_s1_reg <= 1'b1;
      dcd_s2_reg <= 1'b1;
      dsr_old_reg <= 1'b1;
      dcd_old_reg <= 1'b1;
    end else begin
      dsr_s1_reg <= DSR_N_I;
      dsr_s2_reg <= dsr_s1_reg;
      dcd_s1_reg <= DCD_N_I;
      dcd_s2_reg <= dcd_s1_reg;
      dsr_old_reg <= dsr_s2_reg;
      dcd_old_reg <= dcd_s2_reg;
    end
  end
  assign modem_chg = (dsr_s2_reg ^ dsr_old_reg) |
                     (dcd_s2_reg ^ dcd_old_reg);

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: holding register and shifter
  assign tx_load = wr && PADDR_I == ADDR_TX_DATA && !sub_loopy;
  assign tx_done = tx_state_reg == TX_LAST;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_hold_reg <= RESET_BYTE;
      tx_hold_full_reg <= 1'b0;
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 9'h1ff;
      tx_count_reg <= 4'h0;
    end else begin
      if (tx_load) begin
        tx_hold_reg <= PWDATA_I[7:0];
        tx_hold_full_reg <= 1'b1;
      end
      unique case (tx_state_reg)
        TX_IDLE: begin
          // A disabled transmitter starts nothing new
          if (tx_hold_full_reg && tx_en) begin
            tx_shift_reg <= {tx_hold_reg, 1'b0};
            tx_count_reg <= TX_BITS;
            tx_hold_full_reg <= tx_load;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
          tx_count_reg <= tx_count_reg - 4'h1;
          if (tx_count_reg == 4'h1) begin
            tx_state_reg <= TX_LAST;
          end
        end
        TX_LAST: begin
          tx_shift_reg <= 9'h1ff;
          tx_state_reg <= TX_IDLE;
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      TXD_O <= 1'b1;
    end else begin
      TXD_O <= (sub == SUB_LLOOP) ? 1'b1 : tx_shift_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit status flags
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_ready_reg <= 1'b0;
    end else if (sub_loopy) begin
      tx_ready_reg <= 1'b0;
    end else if (tx_load) begin
      tx_ready_reg <= 1'b0;
    end else if (tx_en_rise) begin
      tx_ready_reg <= !tx_hold_full_reg;
    end else if (tx_en) begin
      tx_ready_reg <= !tx_hold_full_reg;
    end
  end

  // Set beats clear: a change in the read cycle is kept
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_empty_reg <= 1'b0;
    end else if (modem_chg || (tx_done && !tx_hold_full_reg &&
                 !(sub == SUB_ECHO && !sync_mode))) begin
      tx_empty_reg <= 1'b1;
    end else if (tx_en_rise || stat_rd) begin
      tx_empty_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive status flags
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rx_data_reg <= RESET_BYTE;
    end else if (RX_VALID_I && rx_en && sub != SUB_RLOOP) begin
      rx_data_reg <= RX_CHAR_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rx_ready_reg <= 1'b0;
    end else if (!rx_en || rx_en_fall) begin
      rx_ready_reg <= 1'b0;
    end else if (RX_VALID_I && sub != SUB_RLOOP) begin
      rx_ready_reg <= 1'b1;
    end else if (data_rd) begin
      rx_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ovr_reg <= 1'b0;
    end else if (!rx_en || rx_en_fall) begin
      ovr_reg <= 1'b0;
    end else if (RX_VALID_I && rx_ready_reg && !data_rd) begin
      ovr_reg <= 1'b1;
    end else if (err_rst) begin
      ovr_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      par_reg <= 1'b0;
      prev_dle_reg <= 1'b0;
    end else if (!rx_en || rx_en_fall) begin
      par_reg <= 1'b0;
      prev_dle_reg <= 1'b0;
    end else if (RX_VALID_I) begin
      if (mode_reg[MODE_PAR_EN] && RX_PAR_ERR_I) begin
        par_reg <= 1'b1;
      end else if (sync_mode && transp && !mode_reg[MODE_PAR_EN] &&
                   is_dle && !prev_dle_reg) begin
        par_reg <= 1'b1;
      end else if (err_rst) begin
        par_reg <= 1'b0;
      end
      // Second DLE of a pair is data, so it does not arm another
      prev_dle_reg <= is_dle && !prev_dle_reg;
    end else if (err_rst) begin
      par_reg <= 1'b0;
    end
  end

  always_comb begin
    syn_hit = 1'b0;
    if (sync_mode && !transp) begin
      syn_hit = mode_reg[MODE_SINGLE_SYN] ? is_first_sync_char :
                (prev_first_sync_char_reg && is_second_sync_char);
    end else if (sync_mode && transp) begin
      syn_hit = synced_reg ? (prev_dle_reg && is_first_sync_char) :
                (mode_reg[MODE_SINGLE_SYN] ? is_first_sync_char :
                 (prev_first_sync_char_reg && is_second_sync_char));
    end else begin
      syn_hit = RX_STOP_ERR_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      prev_first_sync_char_reg <= 1'b0;
      synced_reg <= 1'b0;
    end else if (!rx_en) begin
      prev_first_sync_char_reg <= 1'b0;
      synced_reg <= 1'b0;
    end else if (RX_VALID_I) begin
      prev_first_sync_char_reg <= is_first_sync_char;
      if (syn_hit && sync_mode) begin
        synced_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      frm_reg <= 1'b0;
    end else if (!rx_en || rx_en_fall) begin
      frm_reg <= 1'b0;
    end else if (RX_VALID_I && syn_hit) begin
      frm_reg <= 1'b1;
    end else if ((err_rst && !sync_mode) || (stat_rd && sync_mode)) begin
      frm_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign status = {~dsr_s2_reg, ~dcd_s2_reg, frm_reg, ovr_reg, par_reg,
                   tx_empty_reg, rx_ready_reg, tx_ready_reg};

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      STATUS_O <= RESET_BYTE;
      TX_HOLDING_READY_N_O <= 1'b1;
      RX_HOLDING_READY_N_O <= 1'b1;
      TX_EMPTY_OR_MODEM_CHANGE_N_O <= 1'b1;
      DTR_N_O <= 1'b1;
      RTS_N_O <= 1'b1;
    end else begin
      STATUS_O <= status;
      TX_HOLDING_READY_N_O <= sub_loopy | ~tx_ready_reg;
      RX_HOLDING_READY_N_O <= (sub == SUB_RLOOP) | ~rx_ready_reg;
      TX_EMPTY_OR_MODEM_CHANGE_N_O <= (sub == SUB_RLOOP) |
                                      ~tx_empty_reg;
      DTR_N_O <= (sub == SUB_LLOOP) | ~command_control_reg[CMD_DTR];
      RTS_N_O <= (sub == SUB_LLOOP) | ~command_control_reg[CMD_RTS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky while a flag is high, set wins over clear
  // Modem mirror bits left out: a held line would never let go
  assign events = status & 8'h3f;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      irq_status_reg <= RESET_BYTE;
    end else begin
      irq_status_reg <= events | (irq_status_reg &
        ~((wr && PADDR_I == ADDR_IRQ_CLEAR) ? PWDATA_I[7:0] : 8'h00));
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_status_reg & irq_enable_reg);
    end
  end

endmodule

/* File: core/usf_pkg.sv */
package usf_pkg;
  // Register word addresses on APB
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RX_DATA = 8'h08;
  localparam logic [7:0] ADDR_TX_DATA = 8'h0c;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_DLE = 8'h14;
  localparam logic [7:0] ADDR_SYNC = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h24;
  // Command field positions
  localparam int CMD_TX_EN = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RX_EN = 2;
  localparam int CMD_BRK = 3;
  localparam int CMD_ERR_RST = 4;
  localparam int CMD_RTS = 5;
  localparam int CMD_SUB_LO = 6;
  // Status field positions
  localparam int ST_TX_HOLDING_READY = 0;
  localparam int ST_RX_HOLDING_READY = 1;
  localparam int ST_TXEMT = 2;
  localparam int ST_PAR = 3;
  localparam int ST_OVR = 4;
  localparam int ST_FRM = 5;
  localparam int ST_DCD = 6;
  localparam int ST_DSR = 7;
  // Mode field positions (own mode word)
  localparam int MODE_SYNC = 0;
  localparam int MODE_PAR_EN = 1;
  localparam int MODE_TRANSP = 2;
  localparam int MODE_SINGLE_SYN = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef enum logic [1:0] {
    SUB_NORMAL = 2'b00,
    SUB_ECHO = 2'b01,
    SUB_LLOOP = 2'b10,
    SUB_RLOOP = 2'b11
  } usf_sub_e;
  // Transmit shift states, one bit changes per step except LAST back to IDLE
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_LAST = 2'b11
  } usf_tx_e;
  localparam logic [3:0] TX_BITS = 4'h9;
endpackage

/* File: dv/usf_host.sv */
`timescale 1ns/1ps
module usf_host (
  input wire logic clk_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  // No own limit on pready; the bench watchdog cuts a hang
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines show junk, not the last value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

/* File: dv/usf_flags_sva.sv */
`timescale 1ns/1ps
module usf_flags_sva (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic RX_VALID_I,
  input wire logic DSR_N_I,
  input wire logic DCD_N_I,
  input wire logic DTR_N_O,
  input wire logic TX_HOLDING_READY_N_O,
  input wire logic RX_HOLDING_READY_N_O,
  input wire logic [usf_pkg::ST_DSR:0] STATUS_O
);
  import usf_pkg::*;
  logic acc;
  logic wr_cmd;
  logic rd_rx;
  logic rd_st;
  logic [7:0] cmd_q;
  assign acc = PSEL_I && PENABLE_I;
  assign wr_cmd = acc && PWRITE_I && PADDR_I == ADDR_COMMAND;
  assign rd_rx = acc && !PWRITE_I && PADDR_I == ADDR_RX_DATA;
  assign rd_st = acc && !PWRITE_I && PADDR_I == ADDR_STATUS;
  ////////////////////////////////////////
  // Shadow command word, rebuilt from bus writes
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      cmd_q <= 8'h00;
    end else if (wr_cmd) begin
      cmd_q <= PWDATA_I[7:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  chk_overrun_set: assert property (
    RX_VALID_I && STATUS_O[ST_RX_HOLDING_READY] && cmd_q[CMD_RX_EN]
    && cmd_q[7:6] == 2'b00 && !wr_cmd && !rd_rx && !$past(rd_rx)
    |-> ##[1:3] STATUS_O[ST_OVR])
    else $error("overrun not flagged");
  chk_err_reset_clear: assert property (
    wr_cmd && PWDATA_I[CMD_ERR_RST] && !RX_VALID_I ##1 !RX_VALID_I
    |-> ##[0:2] STATUS_O[ST_OVR:ST_PAR] == 2'b00)
    else $error("error reset left flags set");
  chk_rx_off_clear: assert property (
    (!cmd_q[CMD_RX_EN] && cmd_q[7:6] != 2'b10) [*3]
    |-> STATUS_O[ST_FRM:ST_PAR] == 3'b000 && !STATUS_O[ST_RX_HOLDING_READY])
    else $error("receiver off but flags set");
  chk_modem_mirror: assert property (
    ($stable({DSR_N_I, DCD_N_I}) && cmd_q[7:6] != 2'b10) [*6]
    |-> STATUS_O[ST_DSR:ST_DCD] == ~{DSR_N_I, DCD_N_I})
    else $error("modem bits do not mirror inputs");
  chk_modem_change: assert property (
    $changed(DCD_N_I) && cmd_q[7:6] != 2'b10
    ##1 ($stable(DCD_N_I) && !rd_st && !wr_cmd) [*4]
    |-> ##[0:2] STATUS_O[ST_TXEMT])
    else $error("modem change not flagged");
  chk_dtr_level: assert property (
    $stable(cmd_q) [*3]
    |-> DTR_N_O == (!cmd_q[CMD_DTR] || cmd_q[7:6] == 2'b10))
    else $error("terminal ready pin wrong");
  chk_tx_holding_ready_remote: assert property (
    (cmd_q[7:6] == 2'b11) [*3] |-> TX_HOLDING_READY_N_O)
    else $error("tx ready pin low in remote loop");
  chk_rx_holding_ready_pin: assert property (
    !RX_HOLDING_READY_N_O |-> STATUS_O[ST_RX_HOLDING_READY] || $past(STATUS_O[ST_RX_HOLDING_READY]))
    else $error("rx ready pin low without status");
endmodule

/* File: dv/usf_tb.sv */
`timescale 1ns/1ps
module testbench;
  import usf_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready;
  logic [7:0] paddr, rx_char, status;
  logic [31:0] pwdata, prdata;
  logic rx_valid, rx_par, rx_stop, dsr_n, dcd_n;
  logic txd, dtr_n, rts_n, txr_n, rxr_n, txe_n, irq, pslverr;
  int error_cnt = 0;
  int total_checks = 0;
  usf_flags dut (
    .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .RX_VALID_I(rx_valid), .RX_CHAR_I(rx_char), .RX_PAR_ERR_I(rx_par),
    .RX_STOP_ERR_I(rx_stop), .DSR_N_I(dsr_n), .DCD_N_I(dcd_n),
    .TXD_O(txd), .DTR_N_O(dtr_n), .RTS_N_O(rts_n),
    .TX_HOLDING_READY_N_O(txr_n), .RX_HOLDING_READY_N_O(rxr_n),
    .TX_EMPTY_OR_MODEM_CHANGE_N_O(txe_n), .STATUS_O(status), .IRQ_O(irq)
  );
  usf_host host (
    .clk_i(clk), .prdata_i(prdata), .pready_i(pready), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata)
  );
  ////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string w);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string w);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e, w);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rx(input logic [7:0] c, input logic p, input logic s);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    rx_par <= p;
    rx_stop <= s;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rdm(ADDR_COMMAND, 32'hff, 32'h00, "cmd reset");
    rdm(ADDR_STATUS, 32'hff, 32'h00, "status reset");
    rdm(8'h3c, 32'hffffffff, 32'h0, "unmapped read");
    chk({txr_n, rxr_n, txe_n, dtr_n, rts_n}, 32'h1f, "reset pins");
    chk({pslverr, status}, 32'h0, "status port, no error");
    $display("reset test done");
  endtask
  task automatic t_rx();
    wr(ADDR_MODE, 32'h02);
    wr(ADDR_COMMAND, 32'h04);
    rx(8'h41, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rdm(ADDR_STATUS, 32'h3a, 32'h02, "rx ready");
    chk(rxr_n, 32'h0, "rx pin");
    rx(8'h42, 1'b1, 1'b0);
    rdm(ADDR_STATUS, 32'h1a, 32'h1a, "overrun parity");
    rdm(ADDR_RX_DATA, 32'hff, 32'h42, "rx data");
    rdm(ADDR_STATUS, 32'h02, 32'h00, "read clears ready");
    rx(8'h43, 1'b0, 1'b1);
    rdm(ADDR_STATUS, 32'h20, 32'h20, "framing");
    wr(ADDR_COMMAND, 32'h14);
    rdm(ADDR_STATUS, 32'h38, 32'h00, "error reset");
    rdm(ADDR_COMMAND, 32'hff, 32'h04, "reset bit self clears");
    rx(8'h44, 1'b1, 1'b0);
    wr(ADDR_COMMAND, 32'h00);
    rx(8'h45, 1'b0, 1'b0);
    rdm(ADDR_STATUS, 32'h3a, 32'h00, "rx disabled");
    $display("rx test done");
  endtask
  task automatic t_tx();
    wr(ADDR_MODE, 32'h00);
    wr(ADDR_COMMAND, 32'h01);
    rdm(ADDR_STATUS, 32'h05, 32'h01, "tx enable");
    chk(txr_n, 32'h0, "tx ready pin");
    wr(ADDR_TX_DATA, 32'h5a);
    repeat (30) @(posedge clk);
    rdm(ADDR_STATUS, 32'h05, 32'h05, "tx empty");
    chk({txe_n, txd}, 32'h1, "empty pin, idle line");
    rdm(ADDR_STATUS, 32'h04, 32'h00, "read clears empty");
    for (int s = 1; s < 4; s += 2) begin
      wr(ADDR_COMMAND, {24'h0, s[1:0], 6'h01});
      repeat (3) @(posedge clk);
      chk(txr_n, 32'h1, "tx ready pin in echo");
    end
    wr(ADDR_COMMAND, 32'h22);
    repeat (2) @(posedge clk);
    chk({dtr_n, rts_n}, 32'h0, "modem outputs low");
    wr(ADDR_COMMAND, 32'h00);
    repeat (2) @(posedge clk);
    chk({dtr_n, rts_n}, 32'h3, "modem outputs high");
    $display("tx test done");
  endtask
  task automatic t_modem();
    logic [31:0] q;
    host.xfer(1'b0, ADDR_STATUS, 32'h0, q);
    @(posedge clk);
    dsr_n <= 1'b0;
    repeat (6) @(posedge clk);
    rdm(ADDR_STATUS, 32'h84, 32'h84, "dsr low");
    rdm(ADDR_STATUS, 32'h04, 32'h00, "change cleared");
    dcd_n <= 1'b0;
    repeat (6) @(posedge clk);
    rdm(ADDR_STATUS, 32'hc4, 32'hc4, "dcd low");
    dsr_n <= 1'b1;
    dcd_n <= 1'b1;
    repeat (6) @(posedge clk);
    rdm(ADDR_STATUS, 32'hc0, 32'h00, "both high");
    $display("modem test done");
  endtask
  task automatic t_sync();
    wr(ADDR_MODE, 32'h09);
    wr(ADDR_SYNC, 32'h16);
    wr(ADDR_COMMAND, 32'h04);
    rx(8'h16, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rdm(ADDR_STATUS, 32'h20, 32'h20, "sync seen");
    rdm(ADDR_STATUS, 32'h20, 32'h00, "read clears sync");
    wr(ADDR_COMMAND, 32'h00);
    wr(ADDR_MODE, 32'h05);
    wr(ADDR_DLE, 32'h10);
    wr(ADDR_SYNC, 32'h1716);
    wr(ADDR_COMMAND, 32'h04);
    rx(8'h16, 1'b0, 1'b0);
    rx(8'h17, 1'b0, 1'b0);
    rdm(ADDR_STATUS, 32'h28, 32'h20, "sync pair seen");
    rx(8'h10, 1'b0, 1'b0);
    rx(8'h16, 1'b0, 1'b0);
    rdm(ADDR_STATUS, 32'h28, 32'h28, "dle then sync");
    rx(8'h10, 1'b0, 1'b0);
    wr(ADDR_COMMAND, 32'h14);
    rx(8'h10, 1'b0, 1'b0);
    rdm(ADDR_STATUS, 32'h08, 32'h00, "second dle ignored");
    wr(ADDR_COMMAND, 32'h00);
    wr(ADDR_MODE, 32'h00);
    $display("sync test done");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wr(ADDR_IRQ_CLEAR, 32'h3f);
    wr(ADDR_IRQ_ENABLE, 32'h02);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0, "irq idle");
    wr(ADDR_COMMAND, 32'h04);
    rx(8'h61, 1'b0, 1'b0);
    repeat (4) @(posedge clk);
    chk(irq, 32'h1, "irq raised");
    rdm(ADDR_IRQ_STATUS, 32'h02, 32'h02, "irq status");
    wr(ADDR_IRQ_ENABLE, 32'h00);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0, "irq masked");
    host.xfer(1'b0, ADDR_RX_DATA, 32'h0, q);
    wr(ADDR_IRQ_CLEAR, 32'h02);
    wr(ADDR_IRQ_ENABLE, 32'h02);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0, "irq cleared");
    wr(ADDR_COMMAND, 32'h00);
    $display("irq test done");
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    rx_valid = 1'b0;
    rx_char = 8'h00;
    rx_par = 1'b0;
    rx_stop = 1'b0;
    dsr_n = 1'b1;
    dcd_n = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rx();
    t_tx();
    t_modem();
    t_sync();
    t_irq();
    conclude();
  end
  // Whole run is under three hundred cycles; 5000 cycles means a hang
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    conclude();
  end
endmodule
bind usf_flags usf_flags_sva chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .RX_VALID_I(RX_VALID_I), .DSR_N_I(DSR_N_I),
  .DCD_N_I(DCD_N_I), .DTR_N_O(DTR_N_O),
  .TX_HOLDING_READY_N_O(TX_HOLDING_READY_N_O),
  .RX_HOLDING_READY_N_O(RX_HOLDING_READY_N_O), .STATUS_O(STATUS_O)
);
